//--- rtl/fbc_pkg.sv
// constants, register map and types for the frame byte counter
package fbc_pkg;

	// register byte offsets within the slave window
	localparam logic [7:0] OFS_CNT_LO = 8'h00;
	localparam logic [7:0] OFS_CNT_HI = 8'h04;
	localparam logic [7:0] OFS_LIM_LO = 8'h08;
	localparam logic [7:0] OFS_LIM_HI = 8'h0C;
	localparam logic [7:0] OFS_CTRL   = 8'h10;
	localparam logic [7:0] OFS_STAT   = 8'h14;

	// field positions
	localparam int unsigned CTRL_TX_UNMASK = 0;
	localparam int unsigned CTRL_RX_UNMASK = 1;
	localparam int unsigned STAT_TX_BUSY   = 0;
	localparam int unsigned STAT_RX_BUSY   = 1;
	localparam int unsigned STAT_ARMED     = 2;

	// values after reset, and the count increment
	localparam logic [11:0] RST_COUNT = 12'h000;
	localparam logic [11:0] RST_LIMIT = 12'h000;
	localparam logic [1:0]  RST_CTRL  = 2'h0;
	localparam logic [11:0] CNT_ONE   = 12'h001;

	// ahb-lite codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ    = 2'h3;

	typedef enum logic [1:0] {
		FBC_IDLE = 2'b00,
		FBC_TX   = 2'b01,
		FBC_RX   = 2'b10
	} fbc_mode_e;

	// exact byte offset match on the whole low address byte
	function automatic logic fbc_hit(input logic [7:0] addr,
	                                 input logic [7:0] ofs);
		fbc_hit = (addr == ofs);
	endfunction

endpackage

//--- rtl/fbc_reg_if.sv
// register access carrier between bus slave and counter core
`timescale 1ns/100ps
interface fbc_reg_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;

	modport bus (output wr_en, output wr_addr, output wr_data,
	             output rd_addr, input rd_data);
	modport regs (input wr_en, input wr_addr, input wr_data,
	              input rd_addr, output rd_data);
endinterface

//--- rtl/fbc_ahb_slave.sv
// ahb-lite slave front end, zero wait states
`timescale 1ns/100ps
module fbc_ahb_slave (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// ahb-lite
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// register side
	fbc_reg_if.bus           rif
);
	logic        wr_pend;
	logic [7:0]  wr_addr_q;
	logic [31:0] hrdata_q;
	logic        next_wr_pend;
	logic [7:0]  next_wr_addr;
	logic [31:0] next_hrdata;
	logic        valid;

	always_comb begin
		valid = hsel && hready &&
		        (htrans == fbc_pkg::HTRANS_NONSEQ ||
		         htrans == fbc_pkg::HTRANS_SEQ);
		next_wr_pend = valid && hwrite;
		next_wr_addr = valid ? haddr[7:0] : wr_addr_q;
		next_hrdata = (valid && !hwrite) ? rif.rd_data : hrdata_q;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wr_pend   <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q  <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_pend   <= next_wr_pend;
			wr_addr_q <= next_wr_addr;
			hrdata_q  <= next_hrdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	assign hrdata      = hrdata_q;
	assign rif.wr_en   = wr_pend;
	assign rif.wr_addr = wr_addr_q;
	assign rif.wr_data = hwdata;
	assign rif.rd_addr = haddr[7:0];

	logic unused_size;
	assign unused_size = ^hsize;
endmodule // fbc_ahb_slave

//--- rtl/fbc_counter.sv
// frame byte counter with programmable limit and limit events
//
// Local design decisions: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
// How it works
// - one 12-bit byte counter for both directions; top nibble readable.
// - transmit counts each byte after the delimiter, never crc bytes.
// - receive counts fifo writes, skipping preamble and delimiter bytes.
// - 12-bit limit split over low byte and low nibble of high register.
// - reset clears count and limit to zero.
// - reaching limit while transmitting raises tx event when unmasked.
// - reaching limit while receiving raises rx event when unmasked.
// - limit only yields the event, never touches state machines or fifos.
// - upper nibble of high registers written zero; reads here give zero.
module fbc_counter (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// ahb-lite
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// transmit byte events
	input  wire logic        tx_frame_start,
	input  wire logic        tx_byte_sent,
	input  wire logic        tx_byte_is_crc,
	input  wire logic        tx_frame_end,
	// receive byte events
	input  wire logic        rx_frame_start,
	input  wire logic        rx_fifo_write,
	input  wire logic        rx_byte_is_sync,
	input  wire logic        rx_frame_end,
	// limit events to the processor
	output logic             tx_limit_irq,
	output logic             rx_limit_irq
);
	fbc_reg_if rif ();

	fbc_ahb_slave u_bus (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.hrdata    (hrdata),
		.rif       (rif)
	);

	fbc_pkg::fbc_mode_e mode;
	fbc_pkg::fbc_mode_e next_mode;
	logic [11:0]        count;
	logic [11:0]        next_count;
	logic [11:0]        limit;
	logic [11:0]        next_limit;
	logic [1:0]         ctrl;
	logic [1:0]         next_ctrl;
	logic               armed;
	logic               next_armed;
	logic               next_tx_irq;
	logic               next_rx_irq;
	logic               start;
	logic               inc;
	logic               hit;
	logic [11:0]        count_plus;

	// frame mode tracking
	always_comb begin
		next_mode = mode;
		case (mode)
			fbc_pkg::FBC_IDLE: begin
				next_mode = fbc_pkg::FBC_IDLE;
			end
			fbc_pkg::FBC_TX: begin
				if (tx_frame_end)
					next_mode = fbc_pkg::FBC_IDLE;
			end
			fbc_pkg::FBC_RX: begin
				if (rx_frame_end)
					next_mode = fbc_pkg::FBC_IDLE;
			end
			default: begin
				next_mode = fbc_pkg::FBC_IDLE;
			end
		endcase
		if (tx_frame_start)
			next_mode = fbc_pkg::FBC_TX;
		else if (rx_frame_start)
			next_mode = fbc_pkg::FBC_RX;
	end

	// counting, match detect and register writes
	always_comb begin
		start = tx_frame_start || rx_frame_start;
		inc = (mode == fbc_pkg::FBC_TX && tx_byte_sent &&
		       !tx_byte_is_crc) ||
		      (mode == fbc_pkg::FBC_RX && rx_fifo_write &&
		       !rx_byte_is_sync);
		count_plus = count + fbc_pkg::CNT_ONE;
		// a new frame restarts the count from zero
		if (start)
			next_count = fbc_pkg::RST_COUNT;
		else if (inc)
			next_count = count_plus;
		else
			next_count = count;
		hit = inc && !start && armed && (count_plus == limit);
		if (start)
			next_armed = 1'b1;
		else if (hit)
			next_armed = 1'b0;
		else
			next_armed = armed;
		// event pulse only; nothing feeds back to tx or rx control
		next_tx_irq = hit && mode == fbc_pkg::FBC_TX &&
		              ctrl[fbc_pkg::CTRL_TX_UNMASK];
		next_rx_irq = hit && mode == fbc_pkg::FBC_RX &&
		              ctrl[fbc_pkg::CTRL_RX_UNMASK];
		next_limit = limit;
		next_ctrl  = ctrl;
		// count registers take no writes
		if (rif.wr_en) begin
			if (fbc_pkg::fbc_hit(rif.wr_addr, fbc_pkg::OFS_LIM_LO))
				next_limit[7:0] = rif.wr_data[7:0];
			if (fbc_pkg::fbc_hit(rif.wr_addr, fbc_pkg::OFS_LIM_HI))
				next_limit[11:8] = rif.wr_data[3:0];
			if (fbc_pkg::fbc_hit(rif.wr_addr, fbc_pkg::OFS_CTRL))
				next_ctrl = rif.wr_data[1:0];
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode         <= fbc_pkg::FBC_IDLE;
			count        <= fbc_pkg::RST_COUNT;
			limit        <= fbc_pkg::RST_LIMIT;
			ctrl         <= fbc_pkg::RST_CTRL;
			armed        <= 1'b0;
			tx_limit_irq <= 1'b0;
			rx_limit_irq <= 1'b0;
		end else begin
			mode         <= next_mode;
			count        <= next_count;
			limit        <= next_limit;
			ctrl         <= next_ctrl;
			armed        <= next_armed;
			tx_limit_irq <= next_tx_irq;
			rx_limit_irq <= next_rx_irq;
		end
	end

	// read mux, unused bits read zero
	always_comb begin
		rif.rd_data = 32'h0000_0000;
		case (rif.rd_addr)
			fbc_pkg::OFS_CNT_LO: rif.rd_data[7:0] = count[7:0];
			fbc_pkg::OFS_CNT_HI: rif.rd_data[3:0] = count[11:8];
			fbc_pkg::OFS_LIM_LO: rif.rd_data[7:0] = limit[7:0];
			fbc_pkg::OFS_LIM_HI: rif.rd_data[3:0] = limit[11:8];
			fbc_pkg::OFS_CTRL:   rif.rd_data[1:0] = ctrl;
			fbc_pkg::OFS_STAT: begin
				rif.rd_data[fbc_pkg::STAT_TX_BUSY] =
					(mode == fbc_pkg::FBC_TX);
				rif.rd_data[fbc_pkg::STAT_RX_BUSY] =
					(mode == fbc_pkg::FBC_RX);
				rif.rd_data[fbc_pkg::STAT_ARMED] = armed;
			end
			default: rif.rd_data = 32'h0000_0000;
		endcase
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	tx_count_inc_a: assert property (
		(mode == fbc_pkg::FBC_TX && tx_byte_sent && !tx_byte_is_crc &&
		 !start) |=> count == $past(count) + fbc_pkg::CNT_ONE)
		else $error("tx byte not counted");

	tx_crc_skip_a: assert property (
		(mode == fbc_pkg::FBC_TX && tx_byte_is_crc && !start)
		|=> $stable(count))
		else $error("tx crc byte counted");

	rx_count_inc_a: assert property (
		(mode == fbc_pkg::FBC_RX && rx_fifo_write && !rx_byte_is_sync &&
		 !start) |=> count == $past(count) + fbc_pkg::CNT_ONE)
		else $error("rx fifo write not counted");

	rx_sync_skip_a: assert property (
		(mode == fbc_pkg::FBC_RX && rx_byte_is_sync && !start)
		|=> $stable(count))
		else $error("rx sync byte counted");

	count_wr_ignored_a: assert property (
		(rif.wr_en && !inc && !start &&
		 (rif.wr_addr == fbc_pkg::OFS_CNT_LO ||
		  rif.wr_addr == fbc_pkg::OFS_CNT_HI)) |=> $stable(count))
		else $error("software write changed count");

	limit_write_a: assert property (
		(rif.wr_en && rif.wr_addr == fbc_pkg::OFS_LIM_HI)
		|=> limit[11:8] == $past(rif.wr_data[3:0]))
		else $error("limit high nibble not written");

	reset_values_a: assert property (@(posedge ref_clk)
		$fell(rst) |-> (count == fbc_pkg::RST_COUNT &&
		               limit == fbc_pkg::RST_LIMIT))
		else $error("count or limit not cleared by reset");

	tx_irq_cause_a: assert property (
		tx_limit_irq |-> ($past(mode) == fbc_pkg::FBC_TX &&
		                  $past(ctrl[fbc_pkg::CTRL_TX_UNMASK]) &&
		                  $past(armed) && count == $past(count_plus)))
		else $error("tx event without limit match");

	rx_irq_cause_a: assert property (
		rx_limit_irq |-> ($past(mode) == fbc_pkg::FBC_RX &&
		                  $past(ctrl[fbc_pkg::CTRL_RX_UNMASK]) &&
		                  $past(armed) && count == $past(count_plus)))
		else $error("rx event without limit match");

	match_fires_a: assert property (
		(inc && !start && armed && count_plus == limit &&
		 ((mode == fbc_pkg::FBC_TX && ctrl[fbc_pkg::CTRL_TX_UNMASK]) ||
		  (mode == fbc_pkg::FBC_RX && ctrl[fbc_pkg::CTRL_RX_UNMASK])))
		|=> (tx_limit_irq || rx_limit_irq) && !armed)
		else $error("limit match did not raise event");

	once_per_frame_a: assert property (
		(tx_limit_irq || rx_limit_irq) && !start
		|-> !armed ##1 !(tx_limit_irq || rx_limit_irq))
		else $error("limit event repeated in frame");

	idle_hold_a: assert property (
		(mode == fbc_pkg::FBC_IDLE && !start) |=> $stable(count))
		else $error("count moved outside a frame");

	tx_stray_skip_a: assert property (
		(mode == fbc_pkg::FBC_TX && !tx_byte_sent && !start)
		|=> $stable(count))
		else $error("tx count moved without a byte");

	rx_stray_skip_a: assert property (
		(mode == fbc_pkg::FBC_RX && !rx_fifo_write && !start)
		|=> $stable(count))
		else $error("rx count moved without a fifo write");

	start_clear_a: assert property (
		start |=> (count == fbc_pkg::RST_COUNT && armed))
		else $error("frame start did not clear and arm");

	tx_start_mode_a: assert property (
		tx_frame_start |=> mode == fbc_pkg::FBC_TX)
		else $error("tx start did not enter tx mode");

	rx_start_mode_a: assert property (
		(rx_frame_start && !tx_frame_start)
		|=> mode == fbc_pkg::FBC_RX)
		else $error("rx start did not enter rx mode");

	limit_low_write_a: assert property (
		(rif.wr_en && rif.wr_addr == fbc_pkg::OFS_LIM_LO)
		|=> limit[7:0] == $past(rif.wr_data[7:0]))
		else $error("limit low byte not written");

	ctrl_write_a: assert property (
		(rif.wr_en && rif.wr_addr == fbc_pkg::OFS_CTRL)
		|=> ctrl == $past(rif.wr_data[1:0]))
		else $error("event mask not written");

	single_event_a: assert property (
		!(tx_limit_irq && rx_limit_irq))
		else $error("tx and rx events together");

	tx_mask_a: assert property (
		(hit && mode == fbc_pkg::FBC_TX &&
		 !ctrl[fbc_pkg::CTRL_TX_UNMASK]) |=> !tx_limit_irq)
		else $error("masked tx limit raised event");

	rx_mask_a: assert property (
		(hit && mode == fbc_pkg::FBC_RX &&
		 !ctrl[fbc_pkg::CTRL_RX_UNMASK]) |=> !rx_limit_irq)
		else $error("masked rx limit raised event");

	reserved_zero_a: assert property (
		(rif.rd_addr == fbc_pkg::OFS_CNT_HI ||
		 rif.rd_addr == fbc_pkg::OFS_LIM_HI)
		|-> rif.rd_data[31:4] == 28'h000_0000)
		else $error("reserved high bits read nonzero");

	tx_hit_c: cover property (tx_limit_irq);
	rx_hit_c: cover property (rx_limit_irq);
	masked_hit_c: cover property (hit && !(next_tx_irq || next_rx_irq));
	restart_c: cover property (start && mode != fbc_pkg::FBC_IDLE);
	gap_c: cover property (mode == fbc_pkg::FBC_RX && !rx_fifo_write);

endmodule // fbc_counter

//--- tb/fbc_ahb_host.sv
// bus host model issuing single word transfers
`timescale 1ns/100ps
module fbc_ahb_host (
	// clock
	input  wire logic        ref_clk,
	// ahb-lite
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	// wait bound used up
	output logic             stuck
);
	initial begin
		hsel = 1'h0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		hwdata = 32'h0;
		stuck = 1'h0;
	end

	// a phase ends at the edge that samples hready high
	task automatic phase_end();
		int i;
		i = 0;
		@(posedge ref_clk);
		while (hready !== 1'h1) begin
			i++;
			if (i > 40)
				stuck <= 1'h1;
			@(posedge ref_clk);
		end
	endtask

	// callers never aim a write at the count registers
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'h1;
		htrans <= fbc_pkg::HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= wr;
		phase_end();
		htrans <= 2'h0;
		hwdata <= d;
		phase_end();
		q = hrdata;
	endtask
endmodule // fbc_ahb_host

//--- tb/tb.sv
// self-checking bench for the frame byte counter
`timescale 1ns/100ps
module tb;
	logic        ref_clk, rst, hsel, hwrite, hreadyout, hresp, stuck;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        tx_frame_start, tx_byte_sent, tx_byte_is_crc, tx_frame_end;
	logic        rx_frame_start, rx_fifo_write, rx_byte_is_sync, rx_frame_end;
	logic        tx_limit_irq, rx_limit_irq;
	int          bad_count, compares, tx_hits, rx_hits, hit_at, cnt;
	bit          cur_tx;

	fbc_counter uut (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.tx_frame_start, .tx_byte_sent, .tx_byte_is_crc, .tx_frame_end,
		.rx_frame_start, .rx_fifo_write, .rx_byte_is_sync, .rx_frame_end,
		.tx_limit_irq, .rx_limit_irq);
	fbc_ahb_host host (.ref_clk, .hready(hreadyout), .hrdata, .hsel,
		.haddr, .htrans, .hwrite, .hsize, .hwdata, .stuck);

	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end

	// reference count, sampled midway between edges
	always @(negedge ref_clk) begin
		if (tx_limit_irq === 1'h1 || rx_limit_irq === 1'h1)
			hit_at = cnt;
		tx_hits += (tx_limit_irq === 1'h1);
		rx_hits += (rx_limit_irq === 1'h1);
		if (tx_frame_start | rx_frame_start)
			cnt = 0;
		else if (cur_tx ? tx_byte_sent & !tx_byte_is_crc
			: rx_fifo_write & !rx_byte_is_sync)
			cnt++;
	end

	task automatic end_of_test();
		$display("compares %0d bad %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t reg %h want %h", $time, got, exp);
		end
	endtask

	task automatic chk_n(input int got, input int exp);
		compares++;
		if (got != exp) begin
			bad_count++;
			$display("BAD %0t count %0d want %0d", $time, got, exp);
		end
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		host.xfer(1'h0, a, 32'h0, q);
		chk_reg(q, exp);
		chk_reg({31'h0, hresp}, 32'h0);
	endtask

	// status word from the busy and armed flags
	function automatic logic [31:0] stat_word(input bit txb, input bit rxb,
		input bit arm);
		stat_word = 32'h0000_0000;
		stat_word[fbc_pkg::STAT_TX_BUSY] = txb;
		stat_word[fbc_pkg::STAT_RX_BUSY] = rxb;
		stat_word[fbc_pkg::STAT_ARMED] = arm;
	endfunction

	// one frame with random skipped bytes and stray opposite strobes
	task automatic frame(input bit tx, input int n, input logic [11:0] lim,
		input logic [1:0] ctrl);
		int k, h0, r0;
		bit sk, ex, v;
		host.xfer(1'h1, fbc_pkg::OFS_LIM_LO, {24'h0, lim[7:0]}, q);
		host.xfer(1'h1, fbc_pkg::OFS_LIM_HI, {28'h0, lim[11:8]}, q);
		host.xfer(1'h1, fbc_pkg::OFS_CTRL, {30'h0, ctrl}, q);
		reg_rd(fbc_pkg::OFS_LIM_LO, {24'h0, lim[7:0]});
		reg_rd(fbc_pkg::OFS_LIM_HI, {28'h0, lim[11:8]});
		h0 = tx_hits;
		r0 = rx_hits;
		k = 0;
		cur_tx = tx;
		reg_rd(fbc_pkg::OFS_CTRL, {30'h0, ctrl});
		// odd lengths restart from a stray start of the other direction
		if (n[0]) begin
			tx_frame_start <= !tx;
			rx_frame_start <= tx;
			@(posedge ref_clk);
		end
		tx_frame_start <= tx;
		rx_frame_start <= !tx;
		@(posedge ref_clk);
		tx_frame_start <= 1'h0;
		rx_frame_start <= 1'h0;
		reg_rd(fbc_pkg::OFS_STAT, stat_word(tx, !tx, 1'h1));
		for (int i = 0; i < n; i++) begin
			sk = ($urandom % 4) == 0;
			v = ($urandom % 8) != 0;
			k += v && !sk;
			tx_byte_sent <= tx ? v : 1'($urandom);
			tx_byte_is_crc <= tx & sk;
			rx_fifo_write <= tx ? 1'($urandom) : v;
			rx_byte_is_sync <= !tx & sk;
			@(posedge ref_clk);
		end
		{tx_byte_sent, rx_fifo_write, tx_byte_is_crc, rx_byte_is_sync} <= 4'h0;
		tx_frame_end <= tx;
		rx_frame_end <= !tx;
		@(posedge ref_clk);
		{tx_frame_end, rx_frame_end} <= 2'h0;
		@(posedge ref_clk);
		ex = ctrl[tx ? fbc_pkg::CTRL_TX_UNMASK
			: fbc_pkg::CTRL_RX_UNMASK] && lim != 12'h0 && lim <= k;
		chk_n(tx_hits - h0, tx ? ex : 0);
		chk_n(rx_hits - r0, tx ? 0 : ex);
		if (ex)
			chk_n(hit_at, lim);
		reg_rd(fbc_pkg::OFS_CNT_LO, {24'h0, k[7:0]});
		reg_rd(fbc_pkg::OFS_CNT_HI, {28'h0, k[11:8]});
		reg_rd(fbc_pkg::OFS_STAT, stat_word(1'h0, 1'h0,
			!(lim != 12'h000 && lim <= k)));
		$display("frame tx=%0d n=%0d lim=%0d done", tx, n, lim);
	endtask

	initial begin
		wait (stuck === 1'h1);
		bad_count++;
		end_of_test();
	end

	initial begin
		rst = 1'h1;
		{tx_frame_start, tx_byte_sent, tx_byte_is_crc, tx_frame_end} = 4'h0;
		{rx_frame_start, rx_fifo_write, rx_byte_is_sync, rx_frame_end} = 4'h0;
		void'($urandom(41771));
		repeat (5) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		reg_rd(fbc_pkg::OFS_CNT_LO, 32'h0);
		reg_rd(fbc_pkg::OFS_CNT_HI, 32'h0);
		reg_rd(fbc_pkg::OFS_LIM_LO, 32'h0);
		reg_rd(fbc_pkg::OFS_LIM_HI, 32'h0);
		reg_rd(fbc_pkg::OFS_CTRL, 32'h0);
		reg_rd(8'h40, 32'h0);
		$display("reset values done");
		frame(1'h1, 10, 12'h001, 2'h1);
		frame(1'h1, 300, 12'h105, 2'h1);
		frame(1'h0, 300, 12'h105, 2'h2);
		// mid-run reset with a nonzero count and limit
		rst <= 1'h1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		reg_rd(fbc_pkg::OFS_CNT_LO, 32'h0);
		reg_rd(fbc_pkg::OFS_CNT_HI, 32'h0);
		reg_rd(fbc_pkg::OFS_LIM_LO, 32'h0);
		reg_rd(fbc_pkg::OFS_LIM_HI, 32'h0);
		reg_rd(fbc_pkg::OFS_STAT, stat_word(1'h0, 1'h0, 1'h0));
		$display("mid-run reset done");
		frame(1'h1, 20, 12'h003, 2'h2);
		frame(1'h0, 20, 12'h003, 2'h1);
		frame(1'h0, 20, 12'h000, 2'h3);
		for (int j = 0; j < 10; j++)
			frame(1'($urandom), 1 + $urandom % 40, 12'($urandom % 48),
				2'($urandom));
		end_of_test();
	end
endmodule // tb
